// File: hdl/lic_core.sv
// Purpose: Identifier, version, feature, control and vector table entries.
// Assumes: Software accesses are one-cycle strobes; core accepts on ack.
// Notes:   Reads answer one cycle after the strobe on rdata with rvalid.
`timescale 1ns/100ps
module lic_core #(
  parameter int          NUM_EXT     = 4,
  parameter logic [7:0]  VERSION_VAL = 8'h05, // Arbitrary value.
  parameter logic [7:0]  CORE_ID_VAL = 8'h00,
  parameter logic        WIDE_ID_CAP = 1'b1,
  parameter logic        SPECIFIC_END_OF_INTERRUPT_CAP    = 1'b1,
  parameter logic        ENREG_CAP   = 1'b1
) (
  input  wire logic                        clk_sys,
  input  wire logic                        sys_rst,
  input  wire lic_pkg::reg_req_s           req,
  output logic [31:0]                      rdata,
  output logic                             rvalid,
  input  wire logic [lic_pkg::NUM_BASE+NUM_EXT-1:0] src_event,
  input  wire logic [lic_pkg::NUM_BASE+NUM_EXT-1:0] src_level,
  output lic_pkg::delivery_s               deliver,
  input  wire logic                        deliver_ack,
  output logic [7:0]                       core_id_eff,
  output logic                             specific_eoi_pulse,
  output logic [7:0]                       specific_eoi_vector,
  output logic                             illegal_vector_err,
  output logic                             timer_periodic
);
  import lic_pkg::*;
  localparam int N = NUM_BASE + NUM_EXT;

  typedef struct packed {
    logic [N-1:0][31:0] entry;
    logic [N-1:0]       req_pend;
    logic [7:0]         core_id;
    logic [2:0]         ctrl;
    logic [8:0]         spurious;
    logic [31:0]        enables;
    logic [31:0]        rdata;
    logic               rvalid;
    delivery_s          dlv;
    logic [3:0]         dlv_idx;
    logic               specific_end_of_interrupt;
    logic [7:0]         specific_end_of_interrupt_vec;
    logic               err;
  } state_s;

  state_s state_reg;
  state_s state_next;
  logic       is_entry;
  logic [3:0] entry_idx;
  logic       is_enable;
  logic [N-1:0] ready;
  logic       pick_any;
  logic [3:0] pick_idx;

  // ==========================================================
  // Helpers
  // Level triggering only counts for the two local inputs, never smi or nmi.
  function automatic logic is_level(input logic [31:0] e, input int i);
    logic [2:0] m;
    m = e[10:8];
    is_level = e[B_LEVEL] && (i == SRC_LOCAL_INPUT_ZERO || i == SRC_LOCAL_INPUT_ONE)
               && m != MODE_SMI && m != MODE_NMI;
  endfunction : is_level

  function automatic logic bad_vector(input logic [31:0] e);
    bad_vector = (e[10:8] == MODE_FIXED) && (e[7:0] < MIN_VECTOR);
  endfunction : bad_vector

  lic_reg_decode #(.NUM_ENTRIES(N)) u_decode (
    .addr      (req.addr),
    .is_entry  (is_entry),
    .entry_idx (entry_idx),
    .is_enable (is_enable)
  );

  // A source is ready when it has a request and no delivery is under way.
  always_comb begin
    for (int i = 0; i < N; i++) begin
      ready[i] = state_reg.req_pend[i] && !state_reg.dlv.valid;
    end
  end

  lic_deliver_pick #(.N(N)) u_pick (
    .ready (ready),
    .any   (pick_any),
    .idx   (pick_idx)
  );

  // ==========================================================
  // Next-state logic
  always_comb begin
    logic [31:0] e;
    logic [31:0] version_field;
    logic [31:0] feat;
    e    = 32'h0;
    version_field  = {1'b1, 7'h0, 8'(N - 1), 8'h0, VERSION_VAL};
    feat = {8'h0, 8'(NUM_EXT), 13'h0, WIDE_ID_CAP, SPECIFIC_END_OF_INTERRUPT_CAP, ENREG_CAP};
    state_next          = state_reg;
    state_next.rvalid   = 1'b0;
    state_next.specific_end_of_interrupt     = 1'b0;
    state_next.err      = 1'b0;

    // Source events: masked sources are not accepted, and an event is
    // dropped, not held, while the source's remote flag is set.
    for (int i = 0; i < N; i++) begin
      e = state_reg.entry[i];
      if (src_event[i] && !e[B_MASK] && !e[B_REMOTE]) begin
        if (bad_vector(e)) begin
          state_next.err = 1'b1;
        end else if (!is_level(e, i) || src_level[i]) begin
          state_next.req_pend[i]        = 1'b1;
          state_next.entry[i][B_PENDING] = 1'b1;
        end
      end
    end

    // Offer a delivery to the core handler.
    if (pick_any) begin
      e = state_reg.entry[pick_idx];
      state_next.dlv.valid = 1'b1;
      state_next.dlv.mode  = delivery_mode_e'(e[10:8]);
      state_next.dlv.level = is_level(e, int'(pick_idx));
      case (e[10:8])
        MODE_FIXED: state_next.dlv.vector = e[7:0];
        MODE_SMI:   state_next.dlv.vector = SMI_VECTOR;
        default:    state_next.dlv.vector = 8'h0;
      endcase
      state_next.dlv_idx = pick_idx;
      state_next.req_pend[pick_idx] = 1'b0;
    end
    if (state_reg.dlv.valid && deliver_ack) begin
      state_next.dlv.valid = 1'b0;
      // A new request from the same source in this cycle keeps its pending bit.
      if (!state_next.req_pend[state_reg.dlv_idx]) begin
        state_next.entry[state_reg.dlv_idx][B_PENDING] = 1'b0;
      end
      if (state_reg.dlv.level) begin
        state_next.entry[state_reg.dlv_idx][B_REMOTE] = 1'b1;
      end
    end

    // Software reads; unmapped offsets read zero.
    if (req.rd) begin
      state_next.rvalid = 1'b1;
      state_next.rdata  = 32'h0;
      if (is_entry) begin
        state_next.rdata = state_reg.entry[entry_idx];
      end else begin
        case (req.addr)
          OFF_CORE_ID:    state_next.rdata = {state_reg.core_id, 24'h0};
          OFF_VERSION:    state_next.rdata = version_field;
          OFF_SPURIOUS:   state_next.rdata = {23'h0, state_reg.spurious};
          OFF_EXT_FEAT:   state_next.rdata = feat;
          OFF_EXT_CTRL:   state_next.rdata = {29'h0, state_reg.ctrl};
          OFF_ENABLE_REG: state_next.rdata = state_reg.enables;
          default:        state_next.rdata = 32'h0;
        endcase
      end
    end

    // Software writes; read-only fields keep their values.
    if (req.wr) begin
      if (is_entry) begin
        // Read-only bits come from the next state, so a same-cycle event keeps them.
        e = (req.wdata & ENTRY_WR_MASK)
            | (state_next.entry[entry_idx] & ~ENTRY_WR_MASK);
        if (entry_idx != 4'(SRC_TIMER)) begin
          e[B_TIMER_MODE] = 1'b0;
        end
        if (entry_idx != 4'(SRC_LOCAL_INPUT_ZERO) && entry_idx != 4'(SRC_LOCAL_INPUT_ONE)) begin
          e[B_LEVEL] = 1'b0;
        end
        state_next.entry[entry_idx] = e;
      end else begin
        case (req.addr)
          OFF_CORE_ID:  state_next.core_id  = req.wdata[31:24];
          OFF_SPURIOUS: state_next.spurious = req.wdata[8:0];
          OFF_EXT_CTRL: state_next.ctrl     = req.wdata[2:0];
          OFF_ENABLE_REG: begin
            if (state_reg.ctrl[0]) begin
              state_next.enables = req.wdata;
            end
          end
          OFF_SPEC_EOI: begin
            if (state_reg.ctrl[1]) begin
              state_next.specific_end_of_interrupt     = 1'b1;
              state_next.specific_end_of_interrupt_vec = req.wdata[7:0];
            end
          end
          default: ;
        endcase
      end
      // An end of interrupt, or an enabled specific one, clears the remote flag of every entry except one level-accepted in the same cycle, whatever its vector.
      if (req.addr == OFF_EOI || (req.addr == OFF_SPEC_EOI && state_reg.ctrl[1])) begin
        // A level acceptance in the same cycle wins over the clear.
        for (int i = 0; i < N; i++) begin
          if (!(state_reg.dlv.valid && deliver_ack && state_reg.dlv.level
                && 4'(i) == state_reg.dlv_idx)) begin
            state_next.entry[i][B_REMOTE] = 1'b0;
          end
        end
      end
    end

    // While software disabled, every mask is held set.
    if (!state_next.spurious[B_SW_ENABLE]) begin
      for (int i = 0; i < N; i++) begin
        state_next.entry[i][B_MASK] = 1'b1;
      end
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      for (int i = 0; i < N; i++) begin
        state_reg.entry[i] <= ENTRY_RESET;
      end
      state_reg.req_pend <= '0;
      state_reg.core_id  <= CORE_ID_VAL;
      state_reg.ctrl     <= CTRL_RESET;
      state_reg.spurious <= {1'b0, SPUR_RESET};
      state_reg.enables  <= ENABLE_RESET;
      state_reg.rdata    <= 32'h0;
      state_reg.rvalid   <= 1'b0;
      state_reg.dlv      <= '0;
      state_reg.dlv_idx  <= 4'h0;
      state_reg.specific_end_of_interrupt     <= 1'b0;
      state_reg.specific_end_of_interrupt_vec <= 8'h0;
      state_reg.err      <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================================
  // Outputs
  assign rdata               = state_reg.rdata;
  assign rvalid              = state_reg.rvalid;
  assign deliver             = state_reg.dlv;
  assign specific_eoi_pulse  = state_reg.specific_end_of_interrupt;
  assign specific_eoi_vector = state_reg.specific_end_of_interrupt_vec;
  assign illegal_vector_err  = state_reg.err;
  assign timer_periodic      = state_reg.entry[SRC_TIMER][B_TIMER_MODE];
  // Narrow identifiers keep only the low nibble.
  assign core_id_eff = state_reg.ctrl[2] ? state_reg.core_id
                       : {4'h0, state_reg.core_id[3:0] & NIBBLE_MASK};
endmodule : lic_core

// File: hdl/lic_deliver_pick.sv
// Purpose: Picks the lowest-numbered source with a request ready.
// Assumes: At most one delivery offered per cycle.
// Notes:   Fixed priority keeps the timing short.
`timescale 1ns/100ps
module lic_deliver_pick #(
  parameter int N = 10
) (
  input  wire logic [N-1:0] ready,
  output logic              any,
  output logic [3:0]        idx
);
  // ==========================================================
  // Priority pick
  always_comb begin
    any = 1'b0;
    idx = 4'h0;
    for (int i = N - 1; i >= 0; i--) begin
      if (ready[i]) begin
        any = 1'b1;
        idx = 4'(i);
      end
    end
  end
endmodule : lic_deliver_pick

// File: hdl/lic_pkg.sv
// Purpose: Constants and carriers of the local interrupt controller.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Offsets are byte offsets inside a 4-Kbyte window.
package lic_pkg;
  // ==========================================================
  // Register map
  localparam logic [11:0] OFF_CORE_ID    = 12'h020;
  localparam logic [11:0] OFF_VERSION    = 12'h030;
  localparam logic [11:0] OFF_EOI        = 12'h0b0;
  localparam logic [11:0] OFF_SPURIOUS   = 12'h0f0;
  localparam logic [11:0] OFF_ENTRY_BASE = 12'h320;
  localparam logic [11:0] OFF_EXT_FEAT   = 12'h400;
  localparam logic [11:0] OFF_EXT_CTRL   = 12'h410;
  localparam logic [11:0] OFF_SPEC_EOI   = 12'h420;
  localparam logic [11:0] OFF_ENABLE_REG = 12'h480;
  localparam logic [11:0] OFF_EXT_ENTRY  = 12'h500;
  localparam logic [11:0] ENTRY_STRIDE   = 12'h010;
  localparam int          ADDR_W         = 12;
  // ==========================================================
  // Entry fields and reset values
  localparam logic [31:0] ENTRY_RESET    = 32'h0001_0000;
  localparam logic [31:0] ENTRY_WR_MASK  = 32'h0003_87ff;
  localparam int          B_TIMER_MODE   = 17;
  localparam int          B_MASK         = 16;
  localparam int          B_LEVEL        = 15;
  localparam int          B_REMOTE       = 14;
  localparam int          B_PENDING      = 12;
  localparam int          B_SW_ENABLE    = 8;
  localparam logic [7:0]  SPUR_RESET     = 8'hff;
  localparam logic [7:0]  MIN_VECTOR     = 8'h10;
  localparam logic [7:0]  SMI_VECTOR     = 8'h00;
  localparam logic [31:0] ENABLE_RESET   = 32'hffff_ffff;
  localparam logic [2:0]  CTRL_RESET     = 3'h0;
  localparam logic [3:0]  NIBBLE_MASK    = 4'hf;
  // Source indices inside the entry array.
  localparam int SRC_TIMER = 0;
  localparam int SRC_LOCAL_INPUT_ZERO = 3;
  localparam int SRC_LOCAL_INPUT_ONE = 4;
  localparam int SRC_ERROR = 5;
  localparam int NUM_BASE  = 6;
  typedef enum logic [2:0] {
    MODE_FIXED = 3'h0,
    MODE_SMI   = 3'h2,
    MODE_NMI   = 3'h4,
    MODE_EXT   = 3'h7
  } delivery_mode_e;
  // Software access carrier.
  typedef struct packed {
    logic               rd;
    logic               wr;
    logic [ADDR_W-1:0]  addr;
    logic [31:0]        wdata;
  } reg_req_s;
  // Delivery to the core handler.
  typedef struct packed {
    logic               valid;
    delivery_mode_e     mode;
    logic [7:0]         vector;
    logic               level;
  } delivery_s;
endpackage : lic_pkg

// File: hdl/lic_reg_decode.sv
// Purpose: Decodes a window offset into a register selector.
// Assumes: Offsets aligned on 16-byte boundaries.
// Notes:   Pure combinational.
`timescale 1ns/100ps
module lic_reg_decode #(
  parameter int NUM_ENTRIES = 10
) (
  input  wire logic [lic_pkg::ADDR_W-1:0] addr,
  output logic                            is_entry,
  output logic [3:0]                      entry_idx,
  output logic                            is_enable
);
  import lic_pkg::*;
  // ==========================================================
  // Entry and enable-register decode
  always_comb begin
    is_entry  = 1'b0;
    entry_idx = 4'h0;
    is_enable = (addr == OFF_ENABLE_REG);
    if (addr >= OFF_ENTRY_BASE && addr < OFF_ENTRY_BASE + 12'h060) begin
      is_entry  = (addr[3:0] == 4'h0);
      entry_idx = 4'(addr[7:4] - OFF_ENTRY_BASE[7:4]);
    end else if (addr >= OFF_EXT_ENTRY
                 && addr < OFF_EXT_ENTRY + 12'(16 * (NUM_ENTRIES - NUM_BASE))) begin
      is_entry  = (addr[3:0] == 4'h0);
      entry_idx = 4'(addr[7:4] + 4'(NUM_BASE));
    end
  end
endmodule : lic_reg_decode

// File: testbench/lic_core_handler.sv
// Purpose: Behavioural core interrupt handler that takes deliveries.
// Assumes: Offers stand until the acknowledge pulse is sampled.
// Notes:   Slow mode waits six cycles so pending status can be read.
`timescale 1ns/100ps
module lic_core_handler (
  input  wire logic               clk_sys,
  input  wire logic               sys_rst,
  input  wire logic               slow,
  input  wire lic_pkg::delivery_s deliver,
  output logic                    deliver_ack,
  output lic_pkg::delivery_s      last,
  output int                      n_taken
);
  import lic_pkg::*;
  int wait_cnt;
  // One-cycle acknowledge; never re-acks the offer it has just taken.
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      deliver_ack <= 1'b0;
      wait_cnt <= 0;
      n_taken <= 0;
      last <= '0;
    end else if (deliver.valid && !deliver_ack && wait_cnt >= (slow ? 6 : 0)) begin
      deliver_ack <= 1'b1;
      wait_cnt <= 0;
      last <= deliver;
      n_taken <= n_taken + 1;
    end else begin
      deliver_ack <= 1'b0;
      wait_cnt <= (deliver.valid && !deliver_ack) ? wait_cnt + 1 : 0;
    end
  end
endmodule : lic_core_handler

// File: testbench/lic_core_monitor.sv
// Purpose: Concurrent checks on the ports of the local interrupt controller.
// Assumes: One clock, synchronous active-high reset, default capability flags.
// Notes:   Bound into every lic_core instance at the foot of this file.
`timescale 1ns/100ps
module lic_core_monitor #(
  parameter int NUM_EXT = 4
) (
  input wire logic              clk_sys,
  input wire logic              sys_rst,
  input wire lic_pkg::reg_req_s  req,
  input wire logic [31:0]       rdata,
  input wire logic              rvalid,
  input wire lic_pkg::delivery_s deliver,
  input wire logic              deliver_ack,
  input wire logic              illegal_vector_err,
  input wire logic              specific_eoi_pulse
);
  import lic_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // ==========================================================
  // Register answers
  // Every read is answered on the next cycle; a stray pulse would confuse software.
  AST_READ_ANSWER: assert property (req.rd |=> rvalid)
    else $error("read strobe not answered next cycle");
  AST_NO_STRAY_ANSWER: assert property (!req.rd |=> !rvalid)
    else $error("read answer without a read strobe");
  AST_VERSION_FIELDS: assert property (req.rd && req.addr == OFF_VERSION |=>
    rdata[31] && rdata[30:24] == 7'h00 && rdata[23:16] == 8'(NUM_BASE + NUM_EXT - 1))
    else $error("version register fields wrong");
  AST_FEATURE_FIELDS: assert property (req.rd && req.addr == OFF_EXT_FEAT |=>
    rdata == {8'h00, 8'(NUM_EXT), 13'h0000, 3'h7})
    else $error("feature register fields wrong");
  AST_ID_RESERVED: assert property (req.rd && req.addr == OFF_CORE_ID |=>
    rdata[23:0] == 24'h000000)
    else $error("identifier reserved bits not zero");
  AST_ENTRY_RESERVED: assert property (req.rd &&
    (req.addr inside {[12'h320:12'h370], [12'h500:12'h530]}) |=>
    rdata[31:18] == 14'h0000 && !rdata[13] && !rdata[11])
    else $error("entry reserved bits not zero");
  // ==========================================================
  // Delivery to the core handler
  // The offer must not change under the handler before it is taken.
  AST_OFFER_HOLDS: assert property (deliver.valid && !deliver_ack |=>
    deliver.valid && $stable(deliver.vector) && $stable(deliver.mode))
    else $error("delivery offer changed before acknowledge");
  AST_SMI_VECTOR: assert property (deliver.valid && deliver.mode == MODE_SMI |->
    deliver.vector == SMI_VECTOR)
    else $error("system-management delivery carries a vector");
  AST_EDGE_ONLY: assert property (deliver.valid &&
    (deliver.mode == MODE_SMI || deliver.mode == MODE_NMI) |-> !deliver.level)
    else $error("smi or nmi delivered as level");
  AST_FIXED_LEGAL: assert property (deliver.valid && deliver.mode == MODE_FIXED |->
    deliver.vector >= MIN_VECTOR)
    else $error("fixed delivery with illegal vector");
  COV_TAKEN: cover property (deliver.valid && deliver_ack);
  COV_ILLEGAL: cover property (illegal_vector_err);
  COV_SPECIFIC_END_OF_INTERRUPT: cover property (specific_eoi_pulse);
endmodule : lic_core_monitor

bind lic_core lic_core_monitor #(.NUM_EXT(NUM_EXT)) mon (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .req(req), .rdata(rdata), .rvalid(rvalid),
  .deliver(deliver), .deliver_ack(deliver_ack), .illegal_vector_err(illegal_vector_err),
  .specific_eoi_pulse(specific_eoi_pulse)
);

// File: testbench/test_lic_core.sv
// Purpose: Register and delivery tests of the local interrupt controller.
// Assumes: Default parameters, ten entries, handler model on the far side.
// Notes:   Inputs change on the falling edge only.
`timescale 1ns/100ps
module test_lic_core;
  import lic_pkg::*;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  reg_req_s req = '0;
  logic [9:0] src_event = '0;
  logic [9:0] src_level = '0;
  logic [31:0] rdata;
  logic rvalid, deliver_ack, slow, specific_end_of_interrupt, err, periodic;
  logic [7:0] core_id_eff, specific_end_of_interrupt_vec;
  delivery_s deliver, last;
  int n_taken, miscompares, n_compared, n_err, n_specific_end_of_interrupt, k;
  logic [31:0] e;
  logic [2:0] modes [4] = '{MODE_FIXED, MODE_SMI, MODE_NMI, MODE_EXT};
  always #4 clk_sys = ~clk_sys;
  lic_core dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .req(req), .rdata(rdata),
    .rvalid(rvalid), .src_event(src_event), .src_level(src_level), .deliver(deliver),
    .deliver_ack(deliver_ack), .core_id_eff(core_id_eff), .specific_eoi_pulse(specific_end_of_interrupt),
    .specific_eoi_vector(specific_end_of_interrupt_vec), .illegal_vector_err(err), .timer_periodic(periodic));
  lic_core_handler core (.clk_sys(clk_sys), .sys_rst(sys_rst), .slow(slow),
    .deliver(deliver), .deliver_ack(deliver_ack), .last(last), .n_taken(n_taken));
  // Pulse counters, so a one-cycle output is never missed between checks.
  always @(posedge clk_sys) begin
    n_err <= sys_rst ? 0 : n_err + int'(err === 1'b1);
    n_specific_end_of_interrupt <= sys_rst ? 0 : n_specific_end_of_interrupt + int'(specific_end_of_interrupt === 1'b1);
  end
  // ==========================================================
  // Access tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(negedge clk_sys);
    req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(negedge clk_sys);
    req.wr = 1'b0;
  endtask : wr
  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    @(negedge clk_sys);
    req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 32'h0};
    @(negedge clk_sys);
    req.rd = 1'b0;
    chk({31'h0, rvalid}, 32'h1);
    chk(rdata, exp);
  endtask : rchk
  // Fires one source for one cycle, then waits a fixed number of cycles; k holds n_taken from before.
  task automatic fire(input int i, input int waits);
    k = n_taken;
    @(negedge clk_sys);
    src_event[i] = 1'b1;
    @(negedge clk_sys);
    src_event = '0;
    repeat (waits) @(negedge clk_sys);
  endtask : fire
  function automatic logic [11:0] ent(input int i);
    return (i < 6) ? 12'h320 + 12'(16 * i) : 12'h500 + 12'(16 * (i - 6));
  endfunction : ent
  task automatic print_verdict;
    $display("compared %0d, mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict
  // ==========================================================
  // Watchdog: the whole sequence needs well under two thousand cycles.
  initial begin
    repeat (20000) @(posedge clk_sys);
    miscompares++;
    print_verdict();
  end
  // ==========================================================
  // Test sequence
  initial begin
    slow = 1'b1;
    repeat (6) @(negedge clk_sys);
    sys_rst = 1'b0;
    rchk(OFF_VERSION, 32'h8009_0005);
    rchk(OFF_EXT_FEAT, 32'h0004_0007);
    rchk(OFF_EXT_CTRL, 32'h0);
    rchk(12'h7f0, 32'h0);
    for (int i = 0; i < 10; i++) rchk(ent(i), ENTRY_RESET);
    // Software starts disabled; enable it before any mask is cleared.
    rchk(OFF_SPURIOUS, 32'h0000_00ff);
    wr(OFF_SPURIOUS, 32'h0000_01ff);
    wr(OFF_VERSION, 32'h0);
    wr(OFF_EXT_FEAT, 32'h0);
    rchk(OFF_VERSION, 32'h8009_0005);
    rchk(OFF_EXT_FEAT, 32'h0004_0007);
    wr(OFF_CORE_ID, 32'hab00_0000);
    rchk(OFF_CORE_ID, 32'hab00_0000);
    chk({24'h0, core_id_eff}, 32'h0b);
    wr(OFF_EXT_CTRL, 32'h4);
    rchk(OFF_EXT_CTRL, 32'h4);
    chk({24'h0, core_id_eff}, 32'hab);
    wr(ent(0), 32'h0003_0040);
    rchk(ent(0), 32'h0003_0040);
    chk({31'h0, periodic}, 32'h1);
    // Each delivery mode in turn; the slow handler leaves time to see pending.
    foreach (modes[m]) begin
      e = {21'h0, modes[m], 8'h40};
      wr(ent(0), e);
      fire(0, 2);
      rchk(ent(0), e | 32'h1000);
      repeat (12) @(negedge clk_sys);
      chk(n_taken, k + 1);
      chk({29'h0, last.mode}, {29'h0, e[10:8]});
      if (m < 2) chk({24'h0, last.vector}, (m == 0) ? 32'h40 : 32'h0);
      rchk(ent(0), e);
    end
    chk({31'h0, periodic}, 32'h0);
    wr(ent(0), 32'h0000_0005);
    fire(0, 10);
    chk(n_err, 1);
    wr(ent(0), 32'h0001_0040);
    fire(0, 10);
    chk(n_taken, k);
    slow = 1'b0;
    src_level[SRC_LOCAL_INPUT_ZERO] = 1'b1;
    wr(ent(SRC_LOCAL_INPUT_ZERO), 32'h0000_8050);
    fire(SRC_LOCAL_INPUT_ZERO, 6);
    chk({31'h0, last.level}, 32'h1);
    rchk(ent(SRC_LOCAL_INPUT_ZERO), 32'h0000_c050);
    fire(SRC_LOCAL_INPUT_ZERO, 8);
    chk(n_taken, k);
    wr(OFF_EOI, 32'h0);
    rchk(ent(SRC_LOCAL_INPUT_ZERO), 32'h0000_8050);
    wr(OFF_SPURIOUS, 32'h0);
    wr(ent(1), 32'h0000_0040);
    rchk(ent(1), 32'h0001_0040);
    wr(OFF_SPURIOUS, 32'h0000_01ff);
    wr(OFF_SPEC_EOI, 32'h50);
    repeat (3) @(negedge clk_sys);
    chk(n_specific_end_of_interrupt, 0);
    wr(OFF_EXT_CTRL, 32'h6);
    wr(OFF_SPEC_EOI, 32'h50);
    repeat (3) @(negedge clk_sys);
    chk(n_specific_end_of_interrupt, 1);
    chk({24'h0, specific_end_of_interrupt_vec}, 32'h50);
    wr(OFF_ENABLE_REG, 32'h0);
    rchk(OFF_ENABLE_REG, ENABLE_RESET);
    wr(OFF_EXT_CTRL, 32'h7);
    wr(OFF_ENABLE_REG, 32'h0000_00ff);
    rchk(OFF_ENABLE_REG, 32'h0000_00ff);
    print_verdict();
  end
endmodule : test_lic_core
